// file: excl_lane_mux.sv
`timescale 1ns/10ps
`include "excl_mon_regs.svh"

module excl_lane_mux
  import excl_mon_pkg::*;
(
  // Request
  input wire size_t size,
  input wire logic [1:0] addr_lo,
  input wire logic [31:0] data,
  // Lane-placed result
  output logic [31:0] lane_data,
  output logic [3:0] lane_strb
);

  always_comb begin
    lane_data = data;
    lane_strb = `EXCL_STRB_WORD;
    unique case (size)
      `EXCL_SIZE_BYTE: begin
        lane_data = {4{data[7:0]}};
        lane_strb = 4'(`EXCL_STRB_BYTE << addr_lo);
      end
      `EXCL_SIZE_HALF: begin
        lane_data = {2{data[15:0]}};
        lane_strb = 4'(`EXCL_STRB_HALF << {addr_lo[1], 1'b0});
      end
      default: begin
        lane_data = data;
        lane_strb = `EXCL_STRB_WORD;
      end
    endcase
  end

endmodule

// file: excl_mon_pkg.sv
package excl_mon_pkg;
  typedef enum logic [0:0] {
    ST_OPEN,
    ST_EXCLUSIVE
  } mon_state_e;
  typedef logic [1:0] size_t;
endpackage

// file: excl_mon_regs.svh
`ifndef EXCL_MON_REGS_SVH
`define EXCL_MON_REGS_SVH

// Status values returned to a store-exclusive.
`define EXCL_STATUS_OK 1'b0
`define EXCL_STATUS_FAIL 1'b1

// Access size codes.
`define EXCL_SIZE_BYTE 2'h0
`define EXCL_SIZE_HALF 2'h1
`define EXCL_SIZE_WORD 2'h2

// Bus write strobe patterns.
`define EXCL_STRB_NONE 4'h0
`define EXCL_STRB_BYTE 4'h1
`define EXCL_STRB_HALF 4'h3
`define EXCL_STRB_HALF_HI 4'hc
`define EXCL_STRB_WORD 4'hf

// Reset values.
`define EXCL_ADDR_RST 32'h0000_0000
`define EXCL_DATA_RST 32'h0000_0000

`endif

// file: exclusive_access_monitor.sv
// Notes on behaviour
// - Reset leaves monitor open; stores fail.
// - Load-exclusive moves monitor to exclusive.
// - Store writes memory only while exclusive.
// - No prior load or clear makes store fail.
// - Context switch clears exclusive state.
// - Byte, half and word share behaviour.
// - No bus lock; ordinary independent transfers.
`timescale 1ns/10ps
`include "excl_mon_regs.svh"

module exclusive_access_monitor
  import excl_mon_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Pipeline requests
  input wire logic load_exclusive,
  input wire logic store_exclusive,
  input wire logic clear_exclusive,
  input wire logic context_switch,
  input wire size_t req_size,
  input wire logic [31:0] req_addr,
  input wire logic [31:0] req_wdata,
  // Status back to the pipeline
  output logic status_valid_r,
  output logic status_r,
  output logic exclusive_r,
  // Memory side
  output logic mem_rd_r,
  output logic mem_wr_r,
  output logic [31:0] mem_addr_r,
  output logic [31:0] mem_wdata_r,
  output logic [3:0] mem_strb_r,
  output logic mem_lock_r
);

  // ----------------------------------------------------------------
  // Monitor state
  // ----------------------------------------------------------------
  mon_state_e state_r;
  mon_state_e state_nxt;
  logic [31:0] lane_data;
  logic [3:0] lane_strb;
  logic store_ok;

  assign store_ok = store_exclusive && (state_r == ST_EXCLUSIVE);

  // A clear or context switch in the same cycle as a load wins, so a
  // stale reservation can never survive a task change.
  // A store in the same cycle as a load also wins: the store is judged on
  // the old state and always reopens the monitor, so the pair can never
  // leave a reservation behind that a later unrelated store could use.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_OPEN: begin
        if (load_exclusive && !store_exclusive && !clear_exclusive && !context_switch) begin
          state_nxt = ST_EXCLUSIVE;
        end
      end
      ST_EXCLUSIVE: begin
        if (clear_exclusive || context_switch || store_exclusive) begin
          state_nxt = ST_OPEN;
        end else begin
          state_nxt = ST_EXCLUSIVE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_OPEN;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      exclusive_r <= 1'b0;
    end else begin
      exclusive_r <= (state_nxt == ST_EXCLUSIVE);
    end
  end

  // ----------------------------------------------------------------
  // Store status
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_valid_r <= 1'b0;
      status_r <= `EXCL_STATUS_OK;
    end else begin
      status_valid_r <= store_exclusive;
      if (store_exclusive) begin
        status_r <= store_ok ? `EXCL_STATUS_OK : `EXCL_STATUS_FAIL;
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory transfers
  // ----------------------------------------------------------------
  excl_lane_mux u_lane (
    .size(req_size),
    .addr_lo(req_addr[1:0]),
    .data(req_wdata),
    .lane_data(lane_data),
    .lane_strb(lane_strb)
  );

  // Each transfer stands alone; the lock output never rises because the
  // monitor, not the bus, provides the atomicity.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_rd_r <= 1'b0;
      mem_wr_r <= 1'b0;
      mem_addr_r <= `EXCL_ADDR_RST;
      mem_wdata_r <= `EXCL_DATA_RST;
      mem_strb_r <= `EXCL_STRB_NONE;
      mem_lock_r <= 1'b0;
    end else begin
      mem_rd_r <= load_exclusive && !store_exclusive;
      mem_wr_r <= store_ok;
      mem_lock_r <= 1'b0;
      if (load_exclusive || store_exclusive) begin
        mem_addr_r <= req_addr;
      end
      if (store_ok) begin
        mem_wdata_r <= lane_data;
        mem_strb_r <= lane_strb;
      end else begin
        mem_strb_r <= `EXCL_STRB_NONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_open_after_reset: assert property (
    @(posedge clk) $rose(rstn) |-> state_r == ST_OPEN)
    else $error("Monitor not open after reset.");

  a_load_arms: assert property (
    @(posedge clk) disable iff (!rstn)
    load_exclusive && !store_exclusive && !clear_exclusive && !context_switch
    |=> exclusive_r)
    else $error("Load-exclusive did not arm monitor.");

  a_write_needs_excl: assert property (
    @(posedge clk) disable iff (!rstn)
    mem_wr_r |-> $past(state_r) == ST_EXCLUSIVE && $past(store_exclusive))
    else $error("Write issued while monitor open.");

  a_clear_fails_store: assert property (
    @(posedge clk) disable iff (!rstn)
    clear_exclusive && !load_exclusive ##1 store_exclusive |=> status_r && !mem_wr_r)
    else $error("Store after clear did not fail.");

  a_switch_clears: assert property (
    @(posedge clk) disable iff (!rstn)
    context_switch |=> !exclusive_r)
    else $error("Context switch left monitor armed.");

  a_strobe_size: assert property (
    @(posedge clk) disable iff (!rstn)
    store_ok && req_size == `EXCL_SIZE_WORD |=> mem_strb_r == `EXCL_STRB_WORD)
    else $error("Word store strobe wrong.");

  a_no_bus_lock: assert property (
    @(posedge clk) disable iff (!rstn) !mem_lock_r)
    else $error("Bus lock asserted.");

  a_status_reopens: assert property (
    @(posedge clk) disable iff (!rstn)
    store_exclusive |=> status_valid_r && !exclusive_r && (status_r == !mem_wr_r))
    else $error("Store status or reopen wrong.");

  // ----------------------------------------------------------------
  // Checks judged on the armed flag the pipeline sees, plus read, idle strobe and status-hold checks
  // ----------------------------------------------------------------
  // These, except a_load_reads, a_strobe_idle and a_status_holds, use the registered
  // flag rather than the internal state, so a fault in the state decode shows up here.
  a_open_store_fails: assert property (
    @(posedge clk) disable iff (!rstn)
    store_exclusive && !exclusive_r
    |=> status_r == `EXCL_STATUS_FAIL && !mem_wr_r)
    else $error("Store while open did not fail.");

  a_armed_store_writes: assert property (
    @(posedge clk) disable iff (!rstn)
    store_exclusive && exclusive_r
    |=> mem_wr_r && status_r == `EXCL_STATUS_OK)
    else $error("Store while armed did not write.");

  a_load_clear_blocks: assert property (
    @(posedge clk) disable iff (!rstn)
    load_exclusive && (clear_exclusive || context_switch)
    |=> !exclusive_r)
    else $error("Load armed despite clear or switch.");

  a_load_reads: assert property (
    @(posedge clk) disable iff (!rstn)
    load_exclusive && !store_exclusive
    |=> mem_rd_r && mem_addr_r == $past(req_addr))
    else $error("Load did not issue its read.");

  a_byte_strobe: assert property (
    @(posedge clk) disable iff (!rstn)
    store_exclusive && exclusive_r && req_size == `EXCL_SIZE_BYTE
    |=> $onehot(mem_strb_r))
    else $error("Byte store strobe wrong.");

  a_half_strobe: assert property (
    @(posedge clk) disable iff (!rstn)
    store_exclusive && exclusive_r && req_size == `EXCL_SIZE_HALF
    |=> mem_strb_r == `EXCL_STRB_HALF || mem_strb_r == `EXCL_STRB_HALF_HI)
    else $error("Halfword store strobe wrong.");

  a_strobe_idle: assert property (
    @(posedge clk) disable iff (!rstn)
    !mem_wr_r |-> mem_strb_r == `EXCL_STRB_NONE)
    else $error("Strobe active without a write.");

  a_status_holds: assert property (
    @(posedge clk) disable iff (!rstn)
    !store_exclusive |=> $stable(status_r))
    else $error("Status changed without a store.");

endmodule

// file: pipe_model.sv
`timescale 1ns/10ps

module pipe_model
  import excl_mon_pkg::*;
(
  // Orders from the bench
  input wire logic do_ld,
  input wire logic do_st,
  input wire logic do_cl,
  input wire logic do_cs,
  input wire size_t do_sz,
  input wire logic [31:0] do_ad,
  input wire logic [31:0] do_wd,
  // Requests to the monitor
  output logic load_exclusive,
  output logic store_exclusive,
  output logic clear_exclusive,
  output logic context_switch,
  output size_t req_size,
  output logic [31:0] req_addr,
  output logic [31:0] req_wdata
);
  // Issue is one pulse per instruction; the bench already paces it off the edge.
  assign load_exclusive = do_ld;
  assign store_exclusive = do_st;
  assign clear_exclusive = do_cl;
  assign context_switch = do_cs;
  assign req_size = do_sz;
  assign req_addr = do_ad;
  assign req_wdata = do_wd;
endmodule

// file: tb_top.sv
`timescale 1ns/10ps
`define chk(nm, e, a) begin n_tests++; if ((a) !== (e)) begin \
  $display("unexpected %s exp %h got %h", nm, e, a); err_total++; end end

module tb_top;
  import excl_mon_pkg::*;
  logic clk = 0, rstn = 0, ld = 0, st = 0, cl = 0, cs = 0;
  size_t sz = 0, p_sz;
  logic [31:0] ad = 0, wd = 0, p_ad, p_wd, ma, mw;
  logic p_ld, p_st, p_cl, p_cs, sv, stat, ex, rd, wr, lk;
  logic [3:0] sb;
  int err_total = 0, n_tests = 0, cyc = 0, seed = 32'h8173, arm = 0, r;
  int tbl[10] = '{2, 1, 2, 2, 1, 4, 2, 1, 8, 2};

  pipe_model pm (.do_ld(ld), .do_st(st), .do_cl(cl), .do_cs(cs), .do_sz(sz), .do_ad(ad),
    .do_wd(wd), .load_exclusive(p_ld), .store_exclusive(p_st), .clear_exclusive(p_cl),
    .context_switch(p_cs), .req_size(p_sz), .req_addr(p_ad), .req_wdata(p_wd));
  exclusive_access_monitor dut (.clk(clk), .rstn(rstn), .load_exclusive(p_ld),
    .store_exclusive(p_st), .clear_exclusive(p_cl), .context_switch(p_cs), .req_size(p_sz),
    .req_addr(p_ad), .req_wdata(p_wd), .status_valid_r(sv), .status_r(stat),
    .exclusive_r(ex), .mem_rd_r(rd), .mem_wr_r(wr), .mem_addr_r(ma), .mem_wdata_r(mw),
    .mem_strb_r(sb), .mem_lock_r(lk));

  always #12.5 clk = ~clk;

  // A hung run still reaches the verdict.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      results();
    end
  end

  task automatic results;
    if (err_total == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic step(input logic l, s, c, x);
    logic ok;
    logic [31:0] ew;
    logic [3:0] es;
    {ld, st, cl, cs} = {l, s, c, x};
    sz = size_t'($random(seed));
    ad = $random(seed);
    wd = $random(seed);
    ok = s && (arm != 0);
    case (sz)
      2'h0: begin es = 4'h1 << ad[1:0]; ew = {4{wd[7:0]}}; end
      2'h1: begin es = 4'h3 << {ad[1], 1'b0}; ew = {2{wd[15:0]}}; end
      default: begin es = 4'hf; ew = wd; end
    endcase
    @(posedge clk);
    #1;
    `chk("status_valid", s, sv)
    if (s) `chk("status", !ok, stat)
    `chk("write", ok, wr)
    `chk("strobe", ok ? es : 4'h0, sb)
    if (ok) `chk("wdata", ew, mw)
    `chk("read", l && !s, rd)
    if (l || s) `chk("address", ad, ma)
    `chk("lock", 1'b0, lk)
    arm = (s || c || x) ? 0 : (l ? 1 : arm);
    `chk("armed", arm != 0, ex)
  endtask

  initial begin
    repeat (10) @(posedge clk);
    #1 rstn = 1;
    @(posedge clk);
    #1;
    `chk("armed", 1'b0, ex)
    foreach (tbl[i]) step(tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][3]);
    repeat (300) begin
      r = $random(seed);
      step(r[0], r[1] & r[2], r[3] & r[4] & r[5], r[3] & r[4] & r[6]);
    end
    results();
  end
endmodule
